//--- src/rab_ctrl.sv
// Alarm match, shared interrupt pin, compensation pacing and backup switch control
`timescale 1ns/100ps
module rab_ctrl #(
	parameter int unsigned HALF_SEC_DIV = rab_pkg::HALF_SEC_CYCLES,
	parameter int unsigned MS_DIV = rab_pkg::MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rab_pkg::rab_time_s now,
	input wire logic minute_tick,
	input wire logic timer_event,
	input wire logic update_event,
	input wire logic main_supply_monitor,
	input wire logic supply_below_comp,
	output logic irq_n_o,
	output logic irq_n_oe,
	output logic switch_closed,
	output logic monitor_enable,
	output logic comp_start
);

	////////////////////////////////////////////////////////////////////////////
	// Registers and pin inputs

	logic [7:0] min_alarm;
	logic [7:0] hour_alarm;
	logic [7:0] day_alarm;
	logic week_or_date_select;
	rab_pkg::rab_ctrl_s ctrl;
	logic [3:0] backup_fn;
	logic alarm_flag;
	logic timer_flag;
	logic update_flag;
	logic supply_drop_flag;

	logic monitor_sync;
	logic below_comp_sync;
	logic half_tick;
	logic ms_tick;
	logic sec_phase;
	logic sec_tick;
	logic window_start;

	rab_pkg::rab_pwr_e pwr_state;

	rab_sync2 u_sync_monitor (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(main_supply_monitor),
		.sync_out(monitor_sync)
	);

	rab_sync2 u_sync_below (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(supply_below_comp),
		.sync_out(below_comp_sync)
	);

	rab_tick_div #(
		.DIV(HALF_SEC_DIV)
	) u_half_sec (
		.pclk(pclk),
		.presetn(presetn),
		.restart(1'b0),
		.tick(half_tick)
	);

	// Restarted at each off window so the window length is exact in ms
	rab_tick_div #(
		.DIV(MS_DIV)
	) u_ms (
		.pclk(pclk),
		.presetn(presetn),
		.restart(window_start),
		.tick(ms_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait, read data captured in the setup cycle

	logic [7:0] reg_index;
	logic addr_hit;
	logic wr_en;
	logic wr_byte;
	logic [7:0] wdata;
	logic [7:0] next_rdata;

	assign reg_index = paddr[9:2];
	assign wdata = pwdata[7:0];
	assign wr_en = psel && penable && pwrite && addr_hit;
	assign wr_byte = wr_en && pstrb[0];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	always_comb begin
		addr_hit = 1'b0;
		if (paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00) begin
			unique case (reg_index)
				rab_pkg::IDX_MIN_ALARM,
				rab_pkg::IDX_HOUR_ALARM,
				rab_pkg::IDX_DAY_ALARM,
				rab_pkg::IDX_EXTENSION,
				rab_pkg::IDX_FLAGS,
				rab_pkg::IDX_CONTROL,
				rab_pkg::IDX_BACKUP_FN: addr_hit = 1'b1;
				default: addr_hit = 1'b0;
			endcase
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_index)
			rab_pkg::IDX_MIN_ALARM: next_rdata = min_alarm;
			rab_pkg::IDX_HOUR_ALARM: next_rdata = hour_alarm;
			rab_pkg::IDX_DAY_ALARM: next_rdata = day_alarm;
			rab_pkg::IDX_EXTENSION: next_rdata[rab_pkg::WEEK_OR_DATE_SELECT_BIT] = week_or_date_select;
			rab_pkg::IDX_FLAGS: begin
				next_rdata[rab_pkg::UPDATE_FLAG_BIT] = update_flag;
				next_rdata[rab_pkg::TIMER_FLAG_BIT] = timer_flag;
				next_rdata[rab_pkg::ALARM_FLAG_BIT] = alarm_flag;
				next_rdata[rab_pkg::SUPPLY_DROP_FLAG_BIT] = supply_drop_flag;
			end
			rab_pkg::IDX_CONTROL: next_rdata = {ctrl.comp_interval_sel, ctrl.update_irq_enable,
				ctrl.timer_irq_enable, ctrl.alarm_irq_enable, 2'b00, ctrl.alarm_hold};
			rab_pkg::IDX_BACKUP_FN: next_rdata = {4'h0, backup_fn};
			default: next_rdata = 8'h00;
		endcase
		if (!addr_hit) begin
			next_rdata = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, next_rdata};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			min_alarm <= rab_pkg::ALARM_RESET;
			hour_alarm <= rab_pkg::ALARM_RESET;
			day_alarm <= rab_pkg::ALARM_RESET;
			week_or_date_select <= 1'b0;
		end else if (wr_byte) begin
			if (reg_index == rab_pkg::IDX_MIN_ALARM) begin
				min_alarm <= wdata;
			end
			if (reg_index == rab_pkg::IDX_HOUR_ALARM) begin
				hour_alarm <= wdata;
			end
			if (reg_index == rab_pkg::IDX_DAY_ALARM) begin
				day_alarm <= wdata;
			end
			if (reg_index == rab_pkg::IDX_EXTENSION) begin
				week_or_date_select <= wdata[rab_pkg::WEEK_OR_DATE_SELECT_BIT];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= rab_pkg::rab_ctrl_s'(rab_pkg::CONTROL_RESET[7:3] << 1);
			backup_fn <= rab_pkg::BACKUP_FN_RESET[3:0];
		end else if (wr_byte) begin
			if (reg_index == rab_pkg::IDX_CONTROL) begin
				ctrl.comp_interval_sel <= {wdata[rab_pkg::COMP_INTERVAL_SEL_HI_BIT],
					wdata[rab_pkg::COMP_INTERVAL_SEL_LO_BIT]};
				ctrl.update_irq_enable <= wdata[rab_pkg::UPDATE_IRQ_ENABLE_BIT];
				ctrl.timer_irq_enable <= wdata[rab_pkg::TIMER_IRQ_ENABLE_BIT];
				ctrl.alarm_irq_enable <= wdata[rab_pkg::ALARM_IRQ_ENABLE_BIT];
				ctrl.alarm_hold <= wdata[rab_pkg::ALARM_HOLD_BIT];
			end
			if (reg_index == rab_pkg::IDX_BACKUP_FN) begin
				backup_fn <= wdata[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm comparison, once per minute advance

	logic min_match;
	logic hour_match;
	logic day_match;
	logic alarm_event;
	logic flag_clear_wr;

	assign min_match = min_alarm[rab_pkg::ALARM_FIELD_DISABLE_BIT]
		|| (min_alarm[6:0] == now.minute);
	assign hour_match = hour_alarm[rab_pkg::ALARM_FIELD_DISABLE_BIT]
		|| (hour_alarm[5:0] == now.hour);

	always_comb begin
		if (day_alarm[rab_pkg::ALARM_FIELD_DISABLE_BIT]) begin
			day_match = 1'b1;
		end else if (week_or_date_select) begin
			day_match = (day_alarm[5:0] == now.date);
		end else begin
			day_match = |(day_alarm[6:0] & now.week);
		end
	end

	// Only the minute advance starts a compare, so setting the current time waits for the next minute advance
	assign alarm_event = minute_tick && min_match && hour_match && day_match
		&& !ctrl.alarm_hold;
	assign flag_clear_wr = wr_byte && (reg_index == rab_pkg::IDX_FLAGS);

	////////////////////////////////////////////////////////////////////////////
	// Event flags: set wins over a write of 0, a write of 1 is ignored

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_flag <= 1'b0;
		end else if (alarm_event) begin
			alarm_flag <= 1'b1;
		end else if (flag_clear_wr && !wdata[rab_pkg::ALARM_FLAG_BIT]) begin
			alarm_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_flag <= 1'b0;
		end else if (timer_event) begin
			timer_flag <= 1'b1;
		end else if (flag_clear_wr && !wdata[rab_pkg::TIMER_FLAG_BIT]) begin
			timer_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			update_flag <= 1'b0;
		end else if (update_event) begin
			update_flag <= 1'b1;
		end else if (flag_clear_wr && !wdata[rab_pkg::UPDATE_FLAG_BIT]) begin
			update_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_drop_flag <= 1'b0;
		end else if (below_comp_sync) begin
			supply_drop_flag <= 1'b1;
		end else if (flag_clear_wr && !wdata[rab_pkg::SUPPLY_DROP_FLAG_BIT]) begin
			supply_drop_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared open-drain interrupt pin; the pin is only ever pulled low

	assign irq_n_o = 1'b0;
	assign irq_n_oe = (alarm_flag && ctrl.alarm_irq_enable)
		|| (timer_flag && ctrl.timer_irq_enable)
		|| (update_flag && ctrl.update_irq_enable);

	////////////////////////////////////////////////////////////////////////////
	// One-second tick and temperature compensation pacing

	logic [6:0] comp_count;
	logic [6:0] comp_period;

	assign sec_tick = half_tick && sec_phase;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_phase <= 1'b0;
		end else if (half_tick) begin
			sec_phase <= !sec_phase;
		end
	end

	always_comb begin
		unique case (ctrl.comp_interval_sel)
			2'b00: comp_period = rab_pkg::COMP_HALVES_0;
			2'b01: comp_period = rab_pkg::COMP_HALVES_1;
			2'b10: comp_period = rab_pkg::COMP_HALVES_2;
			2'b11: comp_period = rab_pkg::COMP_HALVES_3;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_count <= 7'h00;
			comp_start <= 1'b0;
		end else begin
			comp_start <= 1'b0;
			if (below_comp_sync) begin
				comp_count <= 7'h00;
			end else if (half_tick) begin
				if (comp_count >= comp_period - 7'h01) begin
					comp_count <= 7'h00;
					comp_start <= 1'b1;
				end else begin
					comp_count <= comp_count + 7'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Backup switch state machine

	logic monitor_off_cfg;
	logic switch_open_cfg;
	logic [8:0] off_ms;
	logic [8:0] off_count;
	logic monitor_prev;
	rab_pkg::rab_pwr_e next_pwr_state;

	assign monitor_off_cfg = backup_fn[rab_pkg::MONITOR_OFF_CFG_BIT];
	assign switch_open_cfg = backup_fn[rab_pkg::SWITCH_OPEN_CFG_BIT];
	assign window_start = (pwr_state == rab_pkg::PWR_NORMAL_ON) && sec_tick && !monitor_off_cfg;

	always_comb begin
		unique case ({backup_fn[rab_pkg::OFF_TIME_SEL_HI_BIT], backup_fn[rab_pkg::OFF_TIME_SEL_LO_BIT]})
			2'b00: off_ms = rab_pkg::OFF_MS_0;
			2'b01: off_ms = rab_pkg::OFF_MS_1;
			2'b10: off_ms = rab_pkg::OFF_MS_2;
			2'b11: off_ms = rab_pkg::OFF_MS_3;
		endcase
	end

	always_comb begin
		next_pwr_state = pwr_state;
		unique case (pwr_state)
			rab_pkg::PWR_BACKUP: begin
				if (sec_tick && !monitor_off_cfg && !monitor_prev && monitor_sync) begin
					next_pwr_state = rab_pkg::PWR_NORMAL_ON;
				end
			end
			rab_pkg::PWR_NORMAL_ON: begin
				if (window_start) begin
					next_pwr_state = rab_pkg::PWR_NORMAL_OFF;
				end
			end
			rab_pkg::PWR_NORMAL_OFF: begin
				if (ms_tick && off_count >= off_ms - 9'h001) begin
					next_pwr_state = monitor_sync ? rab_pkg::PWR_NORMAL_ON
						: rab_pkg::PWR_BACKUP;
				end
			end
			default: next_pwr_state = rab_pkg::PWR_BACKUP;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_state <= rab_pkg::PWR_BACKUP;
		end else begin
			pwr_state <= next_pwr_state;
		end
	end

	// Last once-a-second sample taken in backup, for the rising detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_prev <= 1'b0;
		end else if (pwr_state != rab_pkg::PWR_BACKUP) begin
			monitor_prev <= 1'b1;
		end else if (sec_tick) begin
			monitor_prev <= monitor_sync;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_count <= 9'h000;
		end else if (window_start) begin
			off_count <= 9'h000;
		end else if (pwr_state == rab_pkg::PWR_NORMAL_OFF && ms_tick) begin
			off_count <= off_count + 9'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_closed <= 1'b0;
			monitor_enable <= 1'b0;
		end else if (monitor_off_cfg) begin
			switch_closed <= !switch_open_cfg;
			monitor_enable <= 1'b0;
		end else begin
			switch_closed <= (next_pwr_state == rab_pkg::PWR_NORMAL_ON);
			monitor_enable <= (next_pwr_state != rab_pkg::PWR_NORMAL_ON);
		end
	end

endmodule // rab_ctrl

//--- common/rab_pkg.sv
// Constants, register map and carrier types of the alarm, compensation and backup control block
// Function
// - Alarm flag rising with alarm enable set drives the interrupt pin low.
// - Alarm enable at 0 blocks alarm interrupt; clearing it releases the pin at once.
// - Alarm low level holds with no timeout until the alarm flag is cleared.
// - Timer and update sources still drive the pin while alarm enable is 0.
// - One pin is shared by timer, alarm, update; host reads flags to tell them apart.
// - Alarm field written 80h to FFh has bit 7 set and is not compared.
// - Hour alarm compares as 24-hour BCD, minute alarm as BCD.
// - Weekday mode: bits 0 to 6 are Sunday to Saturday, any set day matches.
// - Date mode: day alarm holds a BCD date, combined with hour and minute fields.
// - Interval select 00/01/10/11 gives 0.5 s, 2 s, 10 s, 30 s compensation period.
// - At power-up the interval select loads 01, the 2 s interval.
// - Compensation pauses while supply is below threshold and resumes when it rises.
// - Backup state keeps the switch open and samples the supply monitor every second.
// - Cold start begins in backup; first supply detection one second after power-up.
// - Supply monitor low-to-high moves the machine from backup to normal.
// - Normal state opens the switch every second for the selected off time and checks.
// - Supply drop seen in normal state moves the machine to backup.
// - Any alarm field with bit 7 set is left out; remaining fields are compared.
// - Week-or-date select 0 uses the weekday bitmap, 1 uses the BCD date.
// - Alarm flag holds 1 until software writes 0; writing 1 does nothing.
package rab_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MIN_ALARM = 8'h08;
	localparam logic [7:0] IDX_HOUR_ALARM = 8'h09;
	localparam logic [7:0] IDX_DAY_ALARM = 8'h0A;
	localparam logic [7:0] IDX_EXTENSION = 8'h0D;
	localparam logic [7:0] IDX_FLAGS = 8'h0E;
	localparam logic [7:0] IDX_CONTROL = 8'h0F;
	localparam logic [7:0] IDX_BACKUP_FN = 8'h18;

	// Field positions
	localparam int unsigned ALARM_FIELD_DISABLE_BIT = 7;
	localparam int unsigned WEEK_OR_DATE_SELECT_BIT = 6;
	localparam int unsigned UPDATE_FLAG_BIT = 5;
	localparam int unsigned TIMER_FLAG_BIT = 4;
	localparam int unsigned ALARM_FLAG_BIT = 3;
	localparam int unsigned SUPPLY_DROP_FLAG_BIT = 0;
	localparam int unsigned COMP_INTERVAL_SEL_HI_BIT = 7;
	localparam int unsigned COMP_INTERVAL_SEL_LO_BIT = 6;
	localparam int unsigned UPDATE_IRQ_ENABLE_BIT = 5;
	localparam int unsigned TIMER_IRQ_ENABLE_BIT = 4;
	localparam int unsigned ALARM_IRQ_ENABLE_BIT = 3;
	localparam int unsigned ALARM_HOLD_BIT = 0;
	localparam int unsigned MONITOR_OFF_CFG_BIT = 3;
	localparam int unsigned SWITCH_OPEN_CFG_BIT = 2;
	localparam int unsigned OFF_TIME_SEL_HI_BIT = 1;
	localparam int unsigned OFF_TIME_SEL_LO_BIT = 0;

	// Reset values
	localparam logic [7:0] CONTROL_RESET = 8'h40;
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] BACKUP_FN_RESET = 8'h00;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned HALF_SEC_NS = 500_000_000;
	localparam int unsigned MS_NS = 1_000_000;
	localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	// Compensation periods in half seconds: 0.5 s, 2.0 s, 10 s, 30 s
	localparam logic [6:0] COMP_HALVES_0 = 7'h01;
	localparam logic [6:0] COMP_HALVES_1 = 7'h04;
	localparam logic [6:0] COMP_HALVES_2 = 7'h14;
	localparam logic [6:0] COMP_HALVES_3 = 7'h3C;
	// Switch off windows in ms: 2, 16, 128, 256
	localparam logic [8:0] OFF_MS_0 = 9'h002;
	localparam logic [8:0] OFF_MS_1 = 9'h010;
	localparam logic [8:0] OFF_MS_2 = 9'h080;
	localparam logic [8:0] OFF_MS_3 = 9'h100;

	typedef enum logic [2:0] {
		PWR_BACKUP = 3'b001,
		PWR_NORMAL_ON = 3'b010,
		PWR_NORMAL_OFF = 3'b100
	} rab_pwr_e;

	// Current calendar values, BCD except the one-hot weekday
	typedef struct packed {
		logic [6:0] week;
		logic [5:0] date;
		logic [5:0] hour;
		logic [6:0] minute;
	} rab_time_s;

	typedef struct packed {
		logic [1:0] comp_interval_sel;
		logic update_irq_enable;
		logic timer_irq_enable;
		logic alarm_irq_enable;
		logic alarm_hold;
	} rab_ctrl_s;

endpackage

//--- src/rab_sync2.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module rab_sync2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // rab_sync2

//--- src/rab_tick_div.sv
// Free-running divider giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/100ps
module rab_tick_div #(
	parameter int unsigned DIV = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	output logic tick
);
	logic [31:0] count;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (restart) begin
			// The restart cycle counts as the first of the period
			count <= 32'h0000_0001;
			tick <= 1'b0;
		end else if (count >= DIV - 1) begin
			count <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule // rab_tick_div

//--- testbench/rab_host_model.sv
// Host side of the shared open-drain interrupt line
`timescale 1ns/100ps
module rab_host_model (
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	output logic irq_line
);
	// Released line is pulled up; host then reads flags to find the source
	assign irq_line = irq_n_oe ? irq_n_o : 1'h1;
endmodule // rab_host_model

//--- testbench/rab_ctrl_assertions.sv
// Port checker for the control block
`timescale 1ns/100ps
module rab_ctrl_assertions #(
	parameter int unsigned HALF_SEC_DIV = 20,
	parameter int unsigned MS_DIV = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic minute_tick,
	input wire logic timer_event,
	input wire logic update_event,
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	input wire logic switch_closed,
	input wire logic monitor_enable,
	input wire logic comp_start
);
	logic [7:0] ctl;
	logic [15:0] age;
	logic wr;
	logic wr_ctl;
	logic wr_flg;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign wr_ctl = wr && paddr == 12'h03C;
	assign wr_flg = wr && paddr == 12'h038;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= 8'h40;
		end else if (wr_ctl) begin
			ctl <= pwdata[7:0];
		end
	end
	// Cycles since reset release, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 16'h0000;
		end else if (age != 16'hFFFF) begin
			age <= age + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_open_win;
		!switch_closed [*8];
	endsequence
	chk_od_low: assert property (irq_n_oe |-> !irq_n_o)
		else $error("driven interrupt pin not low");
	chk_timer_share: assert property (timer_event && ctl[4] |=> irq_n_oe)
		else $error("timer event did not drive pin");
	chk_update_share: assert property (update_event && ctl[5] |=> irq_n_oe)
		else $error("update event did not drive pin");
	chk_en_release: assert property (wr_ctl && pwdata[5:3] == 3'h0 |=> !irq_n_oe)
		else $error("pin held after enables cleared");
	chk_flag_release: assert property (wr_flg && pwdata[7:0] == 8'h00 && !minute_tick
		&& !timer_event && !update_event |=> !irq_n_oe)
		else $error("pin held after flags cleared");
	chk_irq_hold: assert property (irq_n_oe && !wr_ctl && !wr_flg |=> irq_n_oe)
		else $error("pin released without software");
	chk_comp_pulse: assert property (comp_start |=> !comp_start [*8])
		else $error("compensation pulses too close");
	chk_sw_excl: assert property (switch_closed |-> !monitor_enable)
		else $error("monitor on while switch closed");
	chk_off_win: assert property ($fell(switch_closed) |-> s_open_win)
		else $error("off window too short");
	chk_cold_open: assert property (int'(age) < 2 * HALF_SEC_DIV - 2 |-> !switch_closed)
		else $error("switch closed before first detection");
	chk_bad_addr: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready)
		else $error("misaligned access not refused");
endmodule // rab_ctrl_assertions
bind rab_ctrl rab_ctrl_assertions #(.HALF_SEC_DIV(HALF_SEC_DIV), .MS_DIV(MS_DIV)) chk_u (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
	.minute_tick, .timer_event, .update_event, .irq_n_o, .irq_n_oe, .switch_closed,
	.monitor_enable, .comp_start
);

//--- testbench/tb_top.sv
// Self-checking bench for the control block
`timescale 1ns/100ps
module tb_top;
	localparam int unsigned HS = 20;
	localparam int unsigned MSD = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq_line;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic minute_tick, timer_event, update_event, main_supply_monitor, supply_below_comp;
	logic irq_n_o, irq_n_oe, switch_closed, monitor_enable, comp_start;
	rab_pkg::rab_time_s now;
	int n_fail, checks, cyc;
	rab_ctrl #(.HALF_SEC_DIV(HS), .MS_DIV(MSD)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .now, .minute_tick,
		.timer_event, .update_event, .main_supply_monitor, .supply_below_comp, .irq_n_o,
		.irq_n_oe, .switch_closed, .monitor_enable, .comp_start);
	rab_host_model host_u (.irq_n_o, .irq_n_oe, .irq_line);
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic irq_is(input logic e);
		@(negedge pclk);
		chk({31'h0, irq_line}, {31'h0, e});
	endtask
	task automatic try_alarm(input rab_pkg::rab_time_s t, input logic [31:0] exp);
		@(posedge pclk);
		now <= t;
		minute_tick <= 1'h1;
		@(posedge pclk);
		minute_tick <= 1'h0;
		apb(1'h0, 12'h038, 32'h0);
		chk(rd, exp);
	endtask
	task automatic ev(input logic tm);
		@(posedge pclk);
		timer_event <= tm;
		update_event <= !tm;
		@(posedge pclk);
		timer_event <= 1'h0;
		update_event <= 1'h0;
	endtask
	task automatic wait_comp(output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (comp_start !== 1'h1);
	endtask
	task automatic wait_sw(input logic v);
		int n;
		n = 0;
		while (switch_closed !== v) begin
			@(posedge pclk);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		apb(1'h0, 12'h03C, 32'h0);
		chk(rd, 32'h40);
		apb(1'h0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 12'h044, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'h0, 12'h021, 32'h0);
		chk({31'h0, err}, 32'h1);
		irq_is(1'h1);
		$display("done: reset");
	endtask
	task automatic t_power();
		int n;
		@(negedge pclk);
		chk({30'h0, switch_closed, monitor_enable}, 32'h1);
		@(posedge pclk);
		main_supply_monitor <= 1'h1;
		wait_sw(1'h1);
		chk({31'h0, switch_closed}, 32'h1);
		wait_sw(1'h0);
		n = 0;
		wait_sw(1'h1);
		while (switch_closed !== 1'h1) begin
			@(posedge pclk);
			n++;
		end
		wait_sw(1'h0);
		n = 0;
		while (switch_closed !== 1'h1) begin
			@(posedge pclk);
			n++;
		end
		chk(n, 32'(rab_pkg::OFF_MS_0 * MSD));
		main_supply_monitor <= 1'h0;
		wait_sw(1'h0);
		repeat (12) @(posedge pclk);
		@(negedge pclk);
		chk({30'h0, switch_closed, monitor_enable}, 32'h1);
		apb(1'h1, 12'h060, 32'h0C);
		repeat (2) @(negedge pclk);
		chk({30'h0, switch_closed, monitor_enable}, 32'h0);
		apb(1'h1, 12'h060, 32'h08);
		repeat (2) @(negedge pclk);
		chk({30'h0, switch_closed, monitor_enable}, 32'h2);
		apb(1'h1, 12'h060, 32'h00);
		repeat (2) @(negedge pclk);
		chk({30'h0, switch_closed, monitor_enable}, 32'h1);
		$display("done: power");
	endtask
	task automatic t_alarm();
		apb(1'h1, 12'h020, 32'h59);
		apb(1'h1, 12'h024, 32'h18);
		apb(1'h1, 12'h028, 32'hFF);
		apb(1'h1, 12'h034, 32'h0);
		apb(1'h1, 12'h03C, 32'h48);
		try_alarm({7'h7F, 6'h01, 6'h18, 7'h58}, 32'h0);
		try_alarm({7'h7F, 6'h01, 6'h18, 7'h59}, 32'h8);
		repeat (20) @(posedge pclk);
		irq_is(1'h0);
		apb(1'h1, 12'h038, 32'h08);
		apb(1'h0, 12'h038, 32'h0);
		chk(rd, 32'h8);
		apb(1'h1, 12'h03C, 32'h40);
		irq_is(1'h1);
		apb(1'h1, 12'h03C, 32'h48);
		irq_is(1'h0);
		apb(1'h1, 12'h038, 32'h0);
		irq_is(1'h1);
		$display("done: alarm");
	endtask
	task automatic t_week();
		apb(1'h1, 12'h03C, 32'h40);
		apb(1'h1, 12'h028, 32'h22);
		apb(1'h1, 12'h024, 32'h07);
		apb(1'h1, 12'h020, 32'h80);
		try_alarm({7'h08, 6'h01, 6'h07, 7'h12}, 32'h0);
		try_alarm({7'h20, 6'h01, 6'h07, 7'h12}, 32'h8);
		irq_is(1'h1);
		apb(1'h1, 12'h038, 32'h0);
		apb(1'h1, 12'h034, 32'h40);
		apb(1'h1, 12'h028, 32'h15);
		apb(1'h1, 12'h024, 32'h80);
		apb(1'h1, 12'h020, 32'h30);
		try_alarm({7'h01, 6'h14, 6'h03, 7'h30}, 32'h0);
		try_alarm({7'h00, 6'h15, 6'h21, 7'h30}, 32'h8);
		apb(1'h1, 12'h038, 32'h0);
		$display("done: week and date");
	endtask
	task automatic t_share();
		apb(1'h1, 12'h03C, 32'h30);
		ev(1'h1);
		irq_is(1'h0);
		apb(1'h0, 12'h038, 32'h0);
		chk(rd, 32'h10);
		apb(1'h1, 12'h038, 32'h0);
		ev(1'h0);
		irq_is(1'h0);
		apb(1'h0, 12'h038, 32'h0);
		chk(rd, 32'h20);
		apb(1'h1, 12'h038, 32'h0);
		apb(1'h1, 12'h03C, 32'h00);
		ev(1'h1);
		irq_is(1'h1);
		apb(1'h1, 12'h038, 32'h0);
		$display("done: shared pin");
	endtask
	task automatic t_comp();
		int n;
		int m;
		int per [4] = '{1, 4, 20, 60};
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, 12'h03C, 32'(s << 6));
			wait_comp(n);
			wait_comp(n);
			chk(n, per[s] * HS);
		end
		apb(1'h1, 12'h03C, 32'h00);
		wait_comp(n);
		supply_below_comp <= 1'h1;
		m = 0;
		repeat (100) begin
			@(posedge pclk);
			m = m + (comp_start === 1'h1);
		end
		chk(m, 0);
		apb(1'h0, 12'h038, 32'h0);
		chk(rd, 32'h1);
		supply_below_comp <= 1'h0;
		wait_comp(n);
		chk({31'h0, n >= 1 && n <= HS + 3}, 32'h1);
		apb(1'h1, 12'h038, 32'h0);
		$display("done: compensation");
	endtask
	task automatic give_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, minute_tick, timer_event, update_event} = 6'h00;
		{main_supply_monitor, supply_below_comp, presetn} = 3'h0;
		{paddr, pwdata, now} = '0;
		pstrb = 4'hF;
		{n_fail, checks, cyc} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_power();
		t_alarm();
		t_week();
		t_share();
		t_comp();
		give_verdict();
	end
endmodule // tb_top
